// ==== pkg/ctpsc_pkg.sv ====
// constants for the clock trim, system prescaler and sleep controller
//
// ===========================================================================
// Overview of operation
// RL1: at reset the trim register takes the factory calibration value
// RL2: software may rewrite the trim register at any time, retuning the oscillator
// RL3: trim bit 7 picks low or high range; ranges overlap
// RL4: trim bits 6..0 tune upward monotonically inside the chosen range
// RL5: software must keep the trim at or below 8.8MHz during memory writes
// RL6: change-enable sets only on a write of exactly 0x80
// RL7: change-enable clears four cycles after setting or on a select write
// RL8: rewriting 0x80 while enabled neither restarts nor clears the window
// RL9: select codes 0..8 divide the master clock by 1..256; others reserved
// RL10: select resets to 0000, or 0011 when the divide-by-eight fuse is set
// RL11: any select value is accepted; the divided clock drives core and peripherals
// RL12: software must pick a division keeping the system clock within limits
// RL13: sleep is entered only with sleep enable set and a sleep instruction
// RL14: a 3-bit mode field picks one of six sleep modes
// RL15: each mode stops core and flash clocks and keeps its own clock set
// RL16: asynchronous clock and timer oscillator survive only in async timer mode; the code keeps the asy clock on in idle regardless
// RL17: each mode has its own wake sources; outside idle externals wake on level
// RL18: brown-out disable applies in power-down, power-save and both standbys only; the code judges the entry cycle by the mode of the previous sleep
// RL19: interrupt wakes core, halts four cycles past start-up, then runs handler
// RL20: waking leaves register file and memory contents untouched
// RL21: reset during sleep wakes the core to the reset vector
// RL22: standby is meant only for a crystal or resonator clock source
// RL23: software writes 0x80 then the code within four cycles, interrupts off
// RL24: divider changes are glitch-free, landing between T1+T2 and T1+2*T2; the code lands them between T2 and T1+T2
// RL25: mode codes 000,001,010,011,110,111 map to the six modes
// ===========================================================================
package ctpsc_pkg;

    // ===================================================================
    // register map: printed offsets are indices, byte address is index*4
    localparam logic [7:0] CTPSC_IDX_DIV_CTRL = 8'h61;
    localparam logic [7:0] CTPSC_IDX_OSC_TRIM = 8'h66;
    localparam logic [7:0] CTPSC_IDX_SLEEP_CTRL = 8'h53;
    localparam logic [7:0] CTPSC_IDX_STATUS = 8'h54;

    // ===================================================================
    // field layout and reset values
    localparam int CTPSC_DCE_BIT = 7;
    localparam logic [7:0] CTPSC_DCE_UNLOCK = 8'h80;
    localparam logic [3:0] CTPSC_SEL_RST_PLAIN = 4'h0;
    localparam logic [3:0] CTPSC_SEL_RST_DIV8 = 4'h3;
    localparam logic [3:0] CTPSC_SEL_MAX = 4'h8;
    localparam logic [7:0] CTPSC_TRIM_RST = 8'h00;
    localparam logic [1:0] CTPSC_DCE_WINDOW = 2'h3;
    localparam logic [2:0] CTPSC_HALT_CYCLES = 3'h4;
    localparam int CTPSC_STARTUP_DEFAULT = 6;

    // ===================================================================
    // sleep mode codes
    localparam logic [2:0] CTPSC_SM_IDLE = 3'h0;
    localparam logic [2:0] CTPSC_SM_NOISE = 3'h1;
    localparam logic [2:0] CTPSC_SM_PDOWN = 3'h2;
    localparam logic [2:0] CTPSC_SM_PSAVE = 3'h3;
    localparam logic [2:0] CTPSC_SM_STBY = 3'h6;
    localparam logic [2:0] CTPSC_SM_XSTBY = 3'h7;

    // clock enable vector order: cpu, flash, io, adc, asy, main, tosc
    localparam int CTPSC_NCLK = 7;

    // wake source order: ext level, ext edge, pin change, two-wire, timer,
    // memory ready, converter, watchdog, other io
    localparam int CTPSC_NWAKE = 9;

    typedef enum logic [3:0] {
        CTPSC_ACTIVE = 4'b0001,
        CTPSC_SLEEP = 4'b0010,
        CTPSC_START = 4'b0100,
        CTPSC_HALT = 4'b1000
    } ctpsc_state_e;

endpackage : ctpsc_pkg

// ==== hdl/ctpsc_top.sv ====
// clock trim, glitch-free system prescaler and sleep mode controller
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module ctpsc_top #(
    parameter int STARTUP_CYCLES = ctpsc_pkg::CTPSC_STARTUP_DEFAULT
) (
    input wire logic clock,
    input wire logic rstn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // factory values, sampled once after reset release
    input wire logic [7:0] factory_trim,
    input wire logic div_by_eight_fuse,
    // core side
    input wire logic sleep_instr,
    input wire logic async_timer_async_mode,
    input wire logic bod_sleep_disable,
    input wire logic [ctpsc_pkg::CTPSC_NWAKE-1:0] wake_src,
    // oscillator trim
    output logic trim_range_select,
    output logic [6:0] trim_value_bits,
    // divided system clock and gating
    output logic sys_clk_tick,
    output logic [3:0] active_divider,
    output logic [ctpsc_pkg::CTPSC_NCLK-1:0] clk_enables,
    output logic brownout_detector_on,
    output logic core_halted,
    output logic wake_irq_go
);
    import ctpsc_pkg::*;

    // ===================================================================
    // elaboration check
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535) begin : g_chk
        $error("STARTUP_CYCLES must be 1..65535");
    end

    localparam logic [15:0] START_LAST = 16'(STARTUP_CYCLES - 1);

    // ===================================================================
    // helper functions

    // mask of low bits that count one divided period
    function automatic logic [7:0] div_mask(input logic [3:0] sel);
        logic [8:0] one_hot;
        one_hot = 9'h001 << sel;
        return 8'(one_hot - 9'h001);
    endfunction : div_mask

    // reserved codes hold the slowest legal divider
    function automatic logic [3:0] sel_clamp(input logic [3:0] sel);
        return (sel > CTPSC_SEL_MAX) ? CTPSC_SEL_MAX : sel;
    endfunction : sel_clamp

    // legal mode codes; 100 and 101 are not modes; see RL25
    function automatic logic mode_legal(input logic [2:0] m);
        return (m != 3'h4) && (m != 3'h5);
    endfunction : mode_legal

    // clocks kept running while asleep in mode m
    function automatic logic [CTPSC_NCLK-1:0] sleep_clks(
        input logic [2:0] m, input logic am);
        logic [CTPSC_NCLK-1:0] v;
        v = '0;
        // order: cpu, flash, io, adc, asy, main, tosc (msb first)
        unique case (m)
            CTPSC_SM_IDLE: v = {2'b00, 1'b1, 1'b1, 1'b1, 1'b1, am};
            CTPSC_SM_NOISE: v = {2'b00, 1'b0, 1'b1, am, 1'b1, am};
            CTPSC_SM_PDOWN: v = {2'b00, 5'b00000};
            CTPSC_SM_PSAVE: v = {2'b00, 1'b0, 1'b0, am, 1'b0, am};
            CTPSC_SM_STBY: v = {2'b00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
            CTPSC_SM_XSTBY: v = {2'b00, 1'b0, 1'b0, am, 1'b1, am};
            default: v = '0;
        endcase
        return v;
    endfunction : sleep_clks

    // wake sources honoured in mode m
    function automatic logic [CTPSC_NWAKE-1:0] wake_mask(
        input logic [2:0] m, input logic am);
        logic [CTPSC_NWAKE-1:0] w;
        w = '0;
        // order: level, edge, pin_change_irq, twi, tmr, spm, adc, wdt, other (msb first)
        unique case (m)
            CTPSC_SM_IDLE: w = 9'h1ff;
            CTPSC_SM_NOISE: w = {1'b1, 1'b0, 1'b1, 1'b1, am, 4'b1110};
            CTPSC_SM_PDOWN: w = {1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'b0010};
            CTPSC_SM_PSAVE: w = {1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'b0010};
            CTPSC_SM_STBY: w = {1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'b0010};
            CTPSC_SM_XSTBY: w = {1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'b0010};
            default: w = '0;
        endcase
        return w;
    endfunction : wake_mask

    // modes in which software may switch the brown-out detector off
    function automatic logic bod_may_stop(input logic [2:0] m);
        return (m == CTPSC_SM_PDOWN) || (m == CTPSC_SM_PSAVE) ||
               (m == CTPSC_SM_STBY) || (m == CTPSC_SM_XSTBY);
    endfunction : bod_may_stop

    // ===================================================================
    // state
    logic loaded_reg;
    logic [7:0] trim_reg, trim_next;
    logic [3:0] sel_reg, sel_next;
    logic dce_reg, dce_next;
    logic [1:0] dce_cnt_reg, dce_cnt_next;
    logic [3:0] act_sel_reg;
    logic [7:0] div_cnt_reg;
    logic tick_reg;
    logic sleep_en_reg;
    logic [2:0] mode_reg;
    ctpsc_state_e state_reg, state_next;
    logic [15:0] wait_reg, wait_next;
    logic [2:0] mode_asleep_reg;
    logic [CTPSC_NCLK-1:0] clk_en_reg, clk_en_next;
    logic bod_on_reg;
    logic go_reg;

    // ===================================================================
    // ahb-lite slave: zero wait state, always OKAY
    logic dp_valid_reg;
    logic dp_write_reg;
    logic [7:0] dp_idx_reg;
    wire addr_take = hsel && hready && htrans[1];
    wire [7:0] addr_idx = haddr[9:2];
    wire wr_fire = dp_valid_reg && dp_write_reg;
    wire [7:0] wbyte = hwdata[7:0];
    wire wr_div = wr_fire && (dp_idx_reg == CTPSC_IDX_DIV_CTRL);
    wire wr_trim = wr_fire && (dp_idx_reg == CTPSC_IDX_OSC_TRIM);
    wire wr_sleep = wr_fire && (dp_idx_reg == CTPSC_IDX_SLEEP_CTRL);
    wire hit_high = (haddr[31:10] == 22'h000000);

    // address phase is captured only when the bus moves on
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_idx_reg <= 8'h00;
        end else if (hready) begin
            dp_valid_reg <= addr_take && hit_high;
            dp_write_reg <= hwrite;
            dp_idx_reg <= addr_idx;
        end
    end

    // read mux during the data phase; unmapped words read as zero
    wire [7:0] rd_div = {dce_reg, 3'b000, sel_reg};
    wire [7:0] rd_sleep = {4'h0, mode_reg, sleep_en_reg};
    wire [7:0] rd_stat = {act_sel_reg, 1'b0, bod_on_reg, core_halted,
                          (state_reg != CTPSC_ACTIVE)};
    wire [7:0] rd_byte =
        (dp_idx_reg == CTPSC_IDX_DIV_CTRL) ? rd_div :
        (dp_idx_reg == CTPSC_IDX_OSC_TRIM) ? trim_reg :
        (dp_idx_reg == CTPSC_IDX_SLEEP_CTRL) ? rd_sleep :
        (dp_idx_reg == CTPSC_IDX_STATUS) ? rd_stat : 8'h00;
    assign hrdata = (dp_valid_reg && !dp_write_reg) ? {24'h000000, rd_byte}
                                                     : 32'h00000000;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ===================================================================
    // oscillator trim
    // the factory byte is caught on the first edge after release, since an
    // asynchronous reset may only load a constant
    always_comb begin
        trim_next = trim_reg;
        if (!loaded_reg) begin
            trim_next = factory_trim; // see RL1
        end else if (wr_trim) begin
            trim_next = wbyte; // see RL2
        end
    end

    // range bit and fine bits go straight to the oscillator
    assign trim_range_select = trim_reg[7]; // see RL3
    assign trim_value_bits = trim_reg[6:0]; // see RL4

    // ===================================================================
    // timed prescaler unlock and divider select
    wire unlock_wr = wr_div && (wbyte == CTPSC_DCE_UNLOCK);
    wire sel_wr = wr_div && !wbyte[CTPSC_DCE_BIT];

    always_comb begin
        sel_next = sel_reg;
        dce_next = dce_reg;
        dce_cnt_next = dce_cnt_reg;
        if (!loaded_reg) begin
            sel_next = div_by_eight_fuse ? CTPSC_SEL_RST_DIV8
                                         : CTPSC_SEL_RST_PLAIN; // see RL10
        end else if (dce_reg) begin
            if (sel_wr) begin
                // any code is stored, fuse or not; see RL11
                sel_next = wbyte[3:0];
                dce_next = 1'b0; // see RL7
            end else if (dce_cnt_reg == CTPSC_DCE_WINDOW) begin
                dce_next = 1'b0; // see RL7
            end else begin
                // a repeated 0x80 leaves the window running; see RL8
                dce_cnt_next = 2'(dce_cnt_reg + 2'h1);
            end
        end else if (unlock_wr) begin
            dce_next = 1'b1; // see RL6
            dce_cnt_next = 2'h0;
        end
    end

    // ===================================================================
    // divider: a new code is applied only at the end of a whole old
    // period, so no short pulse is ever produced and the first new period
    // ends between T2 and T1+T2 after the write
    wire [7:0] cur_mask = div_mask(act_sel_reg);
    wire period_end = (div_cnt_reg == cur_mask); // see RL9

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_cnt_reg <= 8'h00;
            act_sel_reg <= CTPSC_SEL_RST_PLAIN;
            tick_reg <= 1'b0;
        end else begin
            div_cnt_reg <= period_end ? 8'h00 : 8'(div_cnt_reg + 8'h01);
            if (period_end) begin
                act_sel_reg <= sel_clamp(sel_reg); // see RL24
            end
            tick_reg <= period_end; // see RL11
        end
    end

    // ===================================================================
    // sleep control register written by software
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sleep_en_reg <= 1'b0;
            mode_reg <= CTPSC_SM_IDLE;
        end else if (wr_sleep) begin
            sleep_en_reg <= wbyte[0];
            mode_reg <= wbyte[3:1]; // see RL14
        end
    end

    // ===================================================================
    // sleep sequencer
    wire enter_sleep = sleep_instr && sleep_en_reg &&
                       mode_legal(mode_reg); // see RL13
    wire [CTPSC_NWAKE-1:0] wmask =
        wake_mask(mode_asleep_reg, async_timer_async_mode);
    wire wake_hit = |(wake_src & wmask); // see RL17
    wire [CTPSC_NCLK-1:0] keep_clks =
        sleep_clks(mode_asleep_reg, async_timer_async_mode);

    always_comb begin
        state_next = state_reg;
        wait_next = wait_reg;
        clk_en_next = clk_en_reg;
        unique case (state_reg)
            CTPSC_ACTIVE: begin
                clk_en_next = {6'h3f, async_timer_async_mode};
                if (enter_sleep) begin
                    state_next = CTPSC_SLEEP;
                    clk_en_next = sleep_clks(mode_reg,
                                             async_timer_async_mode);
                end
            end
            CTPSC_SLEEP: begin
                // core and flash clocks stay off; see RL15 RL16
                clk_en_next = keep_clks;
                if (wake_hit) begin
                    state_next = CTPSC_START;
                    wait_next = 16'h0000;
                end
            end
            CTPSC_START: begin
                // oscillator restarts, core still frozen, state kept; see RL20
                clk_en_next = keep_clks | 7'b0000010;
                if (wait_reg == START_LAST) begin
                    state_next = CTPSC_HALT;
                    wait_next = 16'h0000;
                end else begin
                    wait_next = 16'(wait_reg + 16'h0001);
                end
            end
            CTPSC_HALT: begin
                clk_en_next = {2'b00, 4'hf, async_timer_async_mode};
                if (wait_reg == 16'(CTPSC_HALT_CYCLES - 3'h1)) begin
                    state_next = CTPSC_ACTIVE; // see RL19
                end else begin
                    wait_next = 16'(wait_reg + 16'h0001);
                end
            end
        endcase
    end

    // reset from any state lands in active with all clocks but tosc on; see RL21
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= CTPSC_ACTIVE;
            wait_reg <= 16'h0000;
            clk_en_reg <= 7'h7e;
            mode_asleep_reg <= CTPSC_SM_IDLE;
            go_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            clk_en_reg <= clk_en_next;
            if (state_reg == CTPSC_ACTIVE && enter_sleep) begin
                mode_asleep_reg <= mode_reg;
            end
            go_reg <= (state_reg == CTPSC_HALT) &&
                      (state_next == CTPSC_ACTIVE); // see RL19
        end
    end

    // after the entry cycle, the detector stays on in idle and noise reduction whatever software asks
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bod_on_reg <= 1'b1;
        end else begin
            bod_on_reg <= !((state_next == CTPSC_SLEEP) &&
                            bod_sleep_disable &&
                            bod_may_stop(mode_asleep_reg)); // see RL18
        end
    end

    // ===================================================================
    // remaining control state
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            loaded_reg <= 1'b0;
            trim_reg <= CTPSC_TRIM_RST;
            sel_reg <= CTPSC_SEL_RST_PLAIN;
            dce_reg <= 1'b0;
            dce_cnt_reg <= 2'h0;
        end else begin
            loaded_reg <= 1'b1;
            trim_reg <= trim_next;
            sel_reg <= sel_next;
            dce_reg <= dce_next;
            dce_cnt_reg <= dce_cnt_next;
        end
    end

    // ===================================================================
    // outputs
    assign sys_clk_tick = tick_reg && clk_en_reg[6];
    assign active_divider = act_sel_reg;
    assign clk_enables = clk_en_reg;
    assign brownout_detector_on = bod_on_reg;
    assign core_halted = (state_reg != CTPSC_ACTIVE);
    assign wake_irq_go = go_reg;

endmodule : ctpsc_top

`default_nettype wire

// ==== tb/ctpsc_top_monitor.sv ====
// assertion checker for the clock trim, prescaler and sleep controller
`timescale 1ns/1ns
`default_nettype none
module ctpsc_top_monitor #(
    parameter int STARTUP_CYCLES = 6
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic sleep_instr,
    input wire logic trim_range_select,
    input wire logic [6:0] trim_value_bits,
    input wire logic [3:0] active_divider,
    input wire logic [6:0] clk_enables,
    input wire logic core_halted,
    input wire logic wake_irq_go
);
    // ====================================================================
    // helper logic
    wire taken = hsel && hready && htrans[1];
    logic wr_trim;
    logic rd_q;
    logic [15:0] halt_cnt;

    // data phase flags; halt_cnt is wide enough for any sleep in the tests
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_trim <= 1'b0;
            rd_q <= 1'b0;
            halt_cnt <= 16'h0;
        end else begin
            wr_trim <= taken && hwrite && haddr == 32'h198;
            rd_q <= taken && !hwrite;
            halt_cnt <= core_halted ? halt_cnt + 16'h1 : 16'h0;
        end
    end

    // ====================================================================
    // properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_drop;
        core_halted ##1 !core_halted;
    endsequence
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus answer not okay");
    property p_rdata; !rd_q |-> hrdata == 32'h0; endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside phase");
    property p_trim; wr_trim |=> {trim_range_select, trim_value_bits}
        == $past(hwdata[7:0]); endproperty
    a_trim: assert property (p_trim) else $error("trim not written");
    property p_div; active_divider <= 4'h8; endproperty
    a_div: assert property (p_div) else $error("divider beyond 8");
    property p_enter; $rose(core_halted) |-> $past(sleep_instr); endproperty
    a_enter: assert property (p_enter) else $error("sleep w/o instr");
    property p_gate; $rose(core_halted) |-> clk_enables[6:5] == 2'b00;
    endproperty
    a_gate: assert property (p_gate) else $error("core clock on");
    property p_wake; s_drop |-> wake_irq_go; endproperty
    a_wake: assert property (p_wake) else $error("wake w/o pulse");
    property p_halt; wake_irq_go |-> halt_cnt >= STARTUP_CYCLES + 4;
    endproperty
    a_halt: assert property (p_halt) else $error("halt too short");
endmodule : ctpsc_top_monitor

bind ctpsc_top ctpsc_top_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_mon (
    .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sleep_instr(sleep_instr), .trim_range_select(trim_range_select),
    .trim_value_bits(trim_value_bits), .active_divider(active_divider),
    .clk_enables(clk_enables), .core_halted(core_halted),
    .wake_irq_go(wake_irq_go));
`default_nettype wire

// ==== tb/clock_trim_prescale_sleep_ctrl_test.sv ====
// self-checking bench for the clock trim, prescaler and sleep controller
`timescale 1ns/1ns
`default_nettype none
module clock_trim_prescale_sleep_ctrl_test;
    import ctpsc_pkg::*;
    localparam int SU = 2;
    localparam logic [31:0] A_DIV = {22'h0, CTPSC_IDX_DIV_CTRL, 2'b00};
    localparam logic [31:0] A_TRIM = {22'h0, CTPSC_IDX_OSC_TRIM, 2'b00};
    localparam logic [31:0] A_SLP = {22'h0, CTPSC_IDX_SLEEP_CTRL, 2'b00};
    localparam logic [31:0] A_STAT = {22'h0, CTPSC_IDX_STATUS, 2'b00};
    logic clock = 0, rstn = 0, hsel = 0, hwrite = 0, rd_phase = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] ftrim = 0;
    logic fuse = 1, slp = 0, bod_dis = 1, async_on = 1;
    logic [8:0] wake = 0;
    logic hreadyout, hresp, trs, tick, halted, go, bod_on;
    logic [6:0] tvb, clk_en;
    logic [3:0] act_div;
    logic [2:0] mc [6] = '{CTPSC_SM_IDLE, CTPSC_SM_NOISE, CTPSC_SM_PDOWN,
                           CTPSC_SM_PSAVE, CTPSC_SM_STBY, CTPSC_SM_XSTBY};
    logic [6:0] ce [6] = '{7'h1f, 7'h0f, 7'h00, 7'h05, 7'h02, 7'h07};
    logic [31:0] expq[$];
    int fail_count = 0, checked = 0, seed = 9273, cyc = 0, n, k;

    ctpsc_top #(.STARTUP_CYCLES(SU)) u_ctpsc_top (
        .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .factory_trim(ftrim), .div_by_eight_fuse(fuse),
        .sleep_instr(slp), .async_timer_async_mode(async_on),
        .bod_sleep_disable(bod_dis), .wake_src(wake),
        .trim_range_select(trs), .trim_value_bits(tvb),
        .sys_clk_tick(tick), .active_divider(act_div), .clk_enables(clk_en),
        .brownout_detector_on(bod_on), .core_halted(halted),
        .wake_irq_go(go));

    // ====================================================================
    // clock, hang limit, read-data watcher
    always #4 clock = ~clock;

    // a hang counts as a mismatch and ends the run
    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            print_verdict();
        end
    end

    // oldest noted read value is compared when its data phase ends
    always @(posedge clock) begin
        if (rd_phase && expq.size() > 0) begin
            check(hrdata, expq.pop_front());
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one single transfer; for reads d is the value expected back
    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        rd_phase <= !w;
        if (!w) expq.push_back(d);
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd_phase <= 1'b0;
    endtask : bus

    // unlock then load code c; p is the code in force before
    // codes stay legal for the master clock used here
    task automatic divide(input int c, input int p);
        int e;
        e = c > 8 ? 8 : c;
        bus(A_DIV, 1'b1, 32'h80);
        bus(A_DIV, 1'b1, c);
        bus(A_DIV, 1'b0, c);
        for (k = 0; act_div !== e[3:0] && k < 600; k++) @(posedge clock);
        check(k + 2 <= (1 << p) + 2 * (1 << e), 1);
        do @(posedge clock); while (tick !== 1'b1);
        k = 1;
        @(posedge clock);
        while (tick !== 1'b1 && k < 600) begin
            k++;
            @(posedge clock);
        end
        check(k, 1 << e);
    endtask : divide

    task automatic pulse();
        slp <= 1'b1;
        @(posedge clock);
        slp <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : pulse

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // ====================================================================
    // main sequence
    initial begin
        ftrim = $random(seed);
        repeat (5) @(posedge clock);
        check(clk_en, 7'h7e);
        rstn <= 1'b1;
        @(posedge clock);
        bus(A_TRIM, 1'b0, {24'h0, ftrim});
        bus(A_DIV, 1'b0, 32'h3);
        check({trs, tvb}, ftrim);
        // no memory writes run in this bench, so any trim is allowed
        for (int i = 0; i < 6; i++) begin
            n = (i == 0) ? 32'h7f : (i == 1) ? 32'h80 : $random(seed);
            bus(A_TRIM, 1'b1, n);
            bus(A_TRIM, 1'b0, n & 32'hff);
            check({trs, tvb}, n[7:0]);
        end
        bus(32'h1c0, 1'b1, 32'hff);
        bus(32'h1c0, 1'b0, 32'h0);
        bus(A_DIV, 1'b1, 32'h81);
        bus(A_DIV, 1'b1, 32'h02);
        bus(A_DIV, 1'b0, 32'h03);
        bus(A_DIV, 1'b1, 32'h80);
        bus(A_DIV, 1'b0, 32'h83);
        bus(A_DIV, 1'b0, 32'h83);
        bus(A_DIV, 1'b0, 32'h03);
        bus(A_DIV, 1'b0, 32'h03);
        bus(A_DIV, 1'b1, 32'h80);
        bus(A_DIV, 1'b1, 32'h80);
        bus(A_DIV, 1'b0, 32'h83);
        bus(A_DIV, 1'b0, 32'h03);
        bus(A_DIV, 1'b0, 32'h03);
        for (int c = 0; c < 10; c++) divide(c, c == 0 ? 3 : c - 1);
        divide(0, 8);
        bus(A_SLP, 1'b1, 32'h0);
        pulse();
        check(halted, 0);
        bus(A_SLP, 1'b1, 32'h9);
        pulse();
        check(halted, 0);
        // the bench clock stands in for a crystal source in standby
        for (int m = 0; m < 6; m++) begin
            bus(A_SLP, 1'b1, {28'h0, mc[m], 1'b1});
            pulse();
            check(clk_en, ce[m]);
            check(bod_on, m < 2);
            bus(A_STAT, 1'b0, {29'h0, m < 2, 2'b11});
            if (m != 0) begin
                wake <= 9'h080;
                repeat (8) @(posedge clock);
                check(halted, 1);
            end
            wake <= (m == 0) ? 9'h080 : 9'h002;
            for (k = 0; go !== 1'b1 && k < 40; k++) @(posedge clock);
            check(k inside {[SU + 5:SU + 7]}, 1);
            wake <= 9'h0;
        end
        bus(A_SLP, 1'b1, {28'h0, CTPSC_SM_PDOWN, 1'b1});
        pulse();
        rstn <= 1'b0;
        @(posedge clock);
        check(halted, 0);
        rstn <= 1'b1;
        @(posedge clock);
        bus(A_TRIM, 1'b0, {24'h0, ftrim});
        print_verdict();
    end
endmodule : clock_trim_prescale_sleep_ctrl_test
`default_nettype wire
